// ==== shared/bhs_pkg.sv ====
// Constants, types and state record for the buck hiccup fault sequencer.
// Assumes a single 20 MHz system clock; all times are converted here.
package bhs_pkg;

    localparam int CLK_PERIOD_NS = 50;

    // Times as printed, and their cycle counts (least times round up).
    localparam int COOL_TIME_NS = 5500000;
    localparam int COOL_CYC = (COOL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SS_TIME_NS = 3600000;
    localparam int SS_CYC = (SS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int UV_TIME_NS = 7000;
    localparam int UV_CYC = (UV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLANK_TIME_NS = 200;
    localparam int BLANK_CYC =
        (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MIN_OFF_NS = 200;
    localparam int MIN_OFF_CYC = (MIN_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SW_FREQ_KHZ = 300;
    localparam int SW_CYC = (1000000 / CLK_PERIOD_NS) / SW_FREQ_KHZ;

    // Event counts.
    localparam int LO_TRIP_COUNT = 15;
    localparam int CLEAN_RUN_COUNT = 32;

    // Widths.
    localparam int REF_W = 10;
    localparam int TMR_W = 20;
    localparam int SWC_W = 8;
    localparam int PIN_N = 6;

    // Ramp reset and full-scale values.
    localparam logic [REF_W-1:0] RAMP_RST = 10'h000;
    localparam logic [REF_W-1:0] RAMP_FULL = 10'h3FF;

    typedef enum logic [1:0] {
        BHS_RAMP,
        BHS_RUN,
        BHS_COOL
    } bhs_state_e;

    // Synchronised pin levels.
    typedef struct packed {
        logic lo_ov;
        logic hs_ov;
        logic uv;
        logic pwm_on;
        logic lockout;
        logic shutdown;
    } bhs_pins_s;

    // Gate, reference and status outputs.
    typedef struct packed {
        logic high_gate;
        logic low_gate;
        logic hiccup;
        logic ramp_busy;
        logic uv_enabled;
        logic ext_ss_discharge;
        logic [REF_W-1:0] reference;
    } bhs_out_s;

    typedef struct packed {
        bhs_state_e state;
        logic [TMR_W-1:0] tmr;
        logic [REF_W-1:0] ramp;
        logic [SWC_W-1:0] sw_cnt;
        logic [3:0] blank;
        logic [4:0] lo_cnt;
        logic [5:0] clean_cnt;
        logic [7:0] uv_cnt;
        logic sampled;
        logic cl_mode;
        logic cl_wait;
        bhs_out_s out;
    } bhs_core_s;

endpackage : bhs_pkg

// ==== hw/bhs_pin_sync.sv ====
// Three-stage synchroniser for comparator and control pins.
// Assumes asynchronous pin levels; output follows once stages 2 and 3 agree.
`timescale 1ns/1ps
`default_nettype none

module bhs_pin_sync
    import bhs_pkg::*;
#(
    parameter int W = PIN_N
)
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] pin_async,
    output logic [W-1:0] pin_sync
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } bhs_sync_s;

    bhs_sync_s st_r;
    bhs_sync_s st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.s1 = pin_async;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < W; i++)
        begin
            if (st_r.s2[i] == st_r.s3[i])
            begin
                st_nxt.q[i] = st_r.s3[i];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign pin_sync = st_r.q;

endmodule : bhs_pin_sync

`default_nettype wire

// ==== hw/bhs_sequencer.sv ====
// Hiccup fault sequencer with gate timing for a synchronous buck controller.
// Assumes comparator pins are asynchronous and reference words are
// produced on sys_clk.
//
// Behaviour
// - Hiccup entry turns both gates off and starts a 5.5 ms cool-down.
// - After cool-down an internal 3.6 ms soft-start ramp runs.
// - Fifteen sampled low-side over-limit cycles cause hiccup entry.
// - The low-side comparator is sampled once per cycle at off-time start.
// - 32 consecutive clean cycles between events clear the event counter.
// - A high-side comparator trip causes hiccup entry at once.
// - In steady state, undervoltage held for 7 us causes hiccup entry.
// - The loop reference is the lowest of bandgap, external and ramp.
// - Only lockout or shutdown discharge the external soft-start.
// - Hiccup entry arms the cool-down timer and zeroes the ramp.
// - During a ramp only the two current-limit faults cause hiccup entry.
// - The high-side comparator is ignored for 200 ns after turn-on.
// - A current-limit cycle skips the high pulse until current falls back.
// - Undervoltage monitoring is enabled only after the ramp has finished.
`timescale 1ns/1ps
`default_nettype none

module bhs_sequencer
    import bhs_pkg::*;
#(
    parameter int COOL_CYCLES = bhs_pkg::COOL_CYC,
    parameter int SS_CYCLES = bhs_pkg::SS_CYC,
    parameter int SW_CYCLES = bhs_pkg::SW_CYC
)
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic lowside_overlimit,
    input wire logic highside_overlimit,
    input wire logic output_undervoltage_detect,
    input wire logic pwm_on,
    input wire logic supply_undervoltage_lockout,
    input wire logic shutdown,
    input wire logic [bhs_pkg::REF_W-1:0] bandgap_ref,
    input wire logic [bhs_pkg::REF_W-1:0] ext_soft_start_level,
    output bhs_pkg::bhs_out_s status
);

    import bhs_pkg::*;

    localparam int SS_STEP_RAW = SS_CYCLES >> REF_W;
    localparam int SS_STEP = (SS_STEP_RAW > 0) ? SS_STEP_RAW : 1;
    localparam logic [TMR_W-1:0] COOL_LAST = TMR_W'(COOL_CYCLES - 1);
    localparam logic [TMR_W-1:0] STEP_LAST = TMR_W'(SS_STEP - 1);
    localparam logic [SWC_W-1:0] SW_LAST = SWC_W'(SW_CYCLES - 1);
    localparam logic [SWC_W-1:0] OFF_EDGE = SWC_W'(SW_CYCLES - MIN_OFF_CYC);
    localparam logic [3:0] BLANK_LAST = 4'(BLANK_CYC);
    localparam logic [4:0] LO_LAST = 5'(LO_TRIP_COUNT - 1);
    localparam logic [5:0] CLEAN_LAST = 6'(CLEAN_RUN_COUNT - 1);
    localparam logic [7:0] UV_LAST = 8'(UV_CYC - 1);

    function automatic logic [REF_W-1:0] min2(
        input logic [REF_W-1:0] a,
        input logic [REF_W-1:0] b
    );
        min2 = (a < b) ? a : b;
    endfunction : min2

    bhs_pins_s pins;
    bhs_core_s st_r;
    bhs_core_s st_nxt;
    logic lo_trip;
    logic hs_trip;
    logic uv_trip;
    logic lo_sample;
    logic cycle_start;
    logic powered_down;
    logic handover;

    bhs_pin_sync #(
        .W(PIN_N)
    ) u_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .pin_async({lowside_overlimit, highside_overlimit,
                    output_undervoltage_detect, pwm_on,
                    supply_undervoltage_lockout, shutdown}),
        .pin_sync(pins)
    );

    always_comb
    begin
        st_nxt = st_r;
        powered_down = pins.lockout | pins.shutdown;
        handover = 1'b0;
        cycle_start = (st_r.sw_cnt == '0);
        lo_sample = st_r.out.low_gate & ~st_r.sampled;
        lo_trip = lo_sample & pins.lo_ov & (st_r.lo_cnt == LO_LAST);
        hs_trip = st_r.out.high_gate & (st_r.blank == BLANK_LAST)
            & pins.hs_ov;
        uv_trip = (st_r.state == BHS_RUN) & pins.uv
            & (st_r.uv_cnt == UV_LAST);

        // Switching-cycle timebase.
        st_nxt.sw_cnt = (st_r.sw_cnt == SW_LAST) ? '0 : st_r.sw_cnt + 1'b1;
        if (cycle_start)
        begin
            st_nxt.sampled = 1'b0;
        end

        // Low-side event counting, once per cycle.
        if (lo_sample)
        begin
            st_nxt.sampled = 1'b1;
            st_nxt.cl_mode = pins.lo_ov;
            if (pins.lo_ov)
            begin
                st_nxt.lo_cnt = st_r.lo_cnt + 1'b1;
                st_nxt.clean_cnt = '0;
            end
            else if (st_r.clean_cnt == CLEAN_LAST)
            begin
                st_nxt.lo_cnt = '0;
                st_nxt.clean_cnt = '0;
            end
            else
            begin
                st_nxt.clean_cnt = st_r.clean_cnt + 1'b1;
            end
        end

        // Gate timing with one cycle of dead time between drives.
        st_nxt.out.high_gate = st_r.out.high_gate;
        if (st_r.out.high_gate)
        begin
            if (st_r.blank != BLANK_LAST)
            begin
                st_nxt.blank = st_r.blank + 1'b1;
            end
            if (!pins.pwm_on || st_r.sw_cnt >= OFF_EDGE)
            begin
                st_nxt.out.high_gate = 1'b0;
            end
        end
        else if (cycle_start)
        begin
            if (st_r.cl_mode)
            begin
                st_nxt.cl_wait = 1'b1;
            end
            else if (pins.pwm_on && !st_r.out.low_gate)
            begin
                st_nxt.out.high_gate = 1'b1;
                st_nxt.blank = '0;
                st_nxt.cl_wait = 1'b0;
            end
        end
        else if (st_r.cl_wait && !pins.lo_ov && st_r.sw_cnt < OFF_EDGE)
        begin
            // Current is back below the limit: low drive off first, high next.
            if (st_r.out.low_gate)
            begin
                handover = 1'b1;
            end
            else
            begin
                st_nxt.cl_wait = 1'b0;
                st_nxt.cl_mode = 1'b0;
                st_nxt.out.high_gate = 1'b1;
                st_nxt.blank = '0;
            end
        end
        else if (st_r.sw_cnt == SW_LAST && !st_nxt.cl_mode && pins.pwm_on)
        begin
            handover = 1'b1;
        end
        st_nxt.out.low_gate = ~st_r.out.high_gate & ~st_nxt.out.high_gate
            & ~handover;

        // Undervoltage glitch filter, live only after the ramp.
        if (st_r.state == BHS_RUN && pins.uv)
        begin
            if (st_r.uv_cnt != UV_LAST)
            begin
                st_nxt.uv_cnt = st_r.uv_cnt + 1'b1;
            end
        end
        else
        begin
            st_nxt.uv_cnt = '0;
        end

        unique case (st_r.state)
            BHS_RAMP:
            begin
                if (st_r.tmr == STEP_LAST)
                begin
                    st_nxt.tmr = '0;
                    if (st_r.ramp == RAMP_FULL)
                    begin
                        st_nxt.state = BHS_RUN;
                    end
                    else
                    begin
                        st_nxt.ramp = st_r.ramp + 1'b1;
                    end
                end
                else
                begin
                    st_nxt.tmr = st_r.tmr + 1'b1;
                end
            end
            BHS_RUN:
            begin
                st_nxt.tmr = '0;
            end
            BHS_COOL:
            begin
                st_nxt.out.high_gate = 1'b0;
                st_nxt.out.low_gate = 1'b0;
                if (st_r.tmr == COOL_LAST)
                begin
                    st_nxt.tmr = '0;
                    st_nxt.state = BHS_RAMP;
                end
                else
                begin
                    st_nxt.tmr = st_r.tmr + 1'b1;
                end
            end
        endcase

        // Fault entry; faults are not watched while cooling down.
        if (st_r.state != BHS_COOL && (lo_trip || hs_trip || uv_trip))
        begin
            st_nxt.state = BHS_COOL;
            st_nxt.tmr = '0;
            st_nxt.ramp = RAMP_RST;
            st_nxt.out.high_gate = 1'b0;
            st_nxt.out.low_gate = 1'b0;
            st_nxt.lo_cnt = '0;
            st_nxt.clean_cnt = '0;
            st_nxt.cl_mode = 1'b0;
            st_nxt.cl_wait = 1'b0;
            st_nxt.uv_cnt = '0;
        end

        // Lockout or shutdown restarts from a fresh soft-start.
        if (powered_down)
        begin
            st_nxt = '0;
            st_nxt.state = BHS_RAMP;
            st_nxt.ramp = RAMP_RST;
        end

        st_nxt.out.ext_ss_discharge = powered_down;
        st_nxt.out.hiccup = (st_nxt.state == BHS_COOL);
        st_nxt.out.ramp_busy = (st_nxt.state == BHS_RAMP);
        st_nxt.out.uv_enabled = (st_nxt.state == BHS_RUN);
        st_nxt.out.reference = min2(min2(bandgap_ref, ext_soft_start_level),
            (st_nxt.state == BHS_RUN) ? RAMP_FULL : st_nxt.ramp);
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign status = st_r.out;

endmodule : bhs_sequencer

`default_nettype wire

// ==== bench/bhs_stage.sv ====
// Behavioural power stage and feedback network for the sequencer bench.
// Assumes gate levels from the sequencer and fault requests from the bench.
`timescale 1ns/1ps
`default_nettype none
module bhs_stage
    import bhs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic high_gate,
    input wire logic low_gate,
    input wire logic lo_f,
    input wire logic hs_f,
    input wire logic uv_f,
    output logic lowside_overlimit,
    output logic highside_overlimit,
    output logic output_undervoltage_detect,
    output logic pwm_on
);
    logic [4:0] on_r;
    always_ff @(posedge sys_clk)
        on_r <= !low_gate ? '0 : on_r + {4'h0, on_r != 5'h14};
    // A held short keeps the valley above the limit for 20 low cycles.
    assign lowside_overlimit = lo_f && on_r != 5'h14;
    assign highside_overlimit = hs_f && high_gate;
    assign output_undervoltage_detect = uv_f;
    assign pwm_on = 1'b1;
endmodule : bhs_stage
`default_nettype wire

// ==== bench/bhs_seq_properties.sv ====
// Checker for the hiccup sequencer, bound to its top-level ports.
// Assumes the count parameters are handed on by the bind.
`timescale 1ns/1ps
`default_nettype none
module bhs_seq_chk
    import bhs_pkg::*;
#(
    parameter int COOL_CYCLES = bhs_pkg::COOL_CYC,
    parameter int SS_CYCLES = bhs_pkg::SS_CYC
)
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic highside_overlimit,
    input wire logic output_undervoltage_detect,
    input wire logic supply_undervoltage_lockout,
    input wire logic shutdown,
    input wire logic [bhs_pkg::REF_W-1:0] bandgap_ref,
    input wire logic [bhs_pkg::REF_W-1:0] ext_soft_start_level,
    input wire bhs_pkg::bhs_out_s status
);
    localparam int RAMP_LEN = 1024 * (SS_CYCLES >> 10);
    logic [19:0] hcnt_r;
    logic [15:0] rcnt_r;
    logic [7:0] uvc_r;
    logic [3:0] hsc_r;
    // Ramp length is judged only after a cool-down; reset starts the ramp
    // part-way through its first step and lockout holds ramp_busy high.
    logic seen_r;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            hcnt_r <= '0;
            rcnt_r <= '0;
            uvc_r <= '0;
            hsc_r <= '0;
            seen_r <= 1'b0;
        end
        else
        begin
            hcnt_r <= status.hiccup ? hcnt_r + 1'b1 : '0;
            rcnt_r <= status.ramp_busy ? rcnt_r + 1'b1 : '0;
            uvc_r <= (output_undervoltage_detect && status.uv_enabled)
                ? uvc_r + 1'b1 : '0;
            hsc_r <= (highside_overlimit && status.high_gate)
                ? hsc_r + 1'b1 : '0;
            seen_r <= status.hiccup | (seen_r & ~status.ext_ss_discharge);
        end
    end
    gates_off_a:
        assert property (status.hiccup |-> !status.high_gate
            && !status.low_gate) else $error("gate on in cool-down");
    cool_len_a:
        assert property ($fell(status.hiccup) && hcnt_r != 0 |->
            hcnt_r == COOL_CYCLES && status.ramp_busy)
            else $error("cool-down length wrong");
    ramp_len_a:
        assert property ($fell(status.ramp_busy) && !status.hiccup
            && seen_r |-> rcnt_r == RAMP_LEN && status.uv_enabled)
            else $error("ramp length wrong");
    ref_zero_a:
        assert property ($rose(status.hiccup) |-> status.reference == '0)
            else $error("ramp not zeroed");
    ref_min_a:
        assert property (status.uv_enabled && $stable(bandgap_ref)
            && $stable(ext_soft_start_level) |-> status.reference ==
            (bandgap_ref < ext_soft_start_level ? bandgap_ref
            : ext_soft_start_level)) else $error("reference not lowest");
    ext_hold_a:
        assert property ((!supply_undervoltage_lockout && !shutdown)[*6]
            |-> !status.ext_ss_discharge) else $error("soft-start dumped");
    uv_gate_a:
        assert property (status.ramp_busy |-> !status.uv_enabled)
            else $error("undervoltage live in ramp");
    uv_trip_a:
        assert property (uvc_r == UV_CYC |-> ##[0:8] status.hiccup)
            else $error("undervoltage did not trip");
    hs_trip_a:
        assert property (hsc_r == 4'h5 |-> ##[0:4] status.hiccup)
            else $error("high-side trip missed");
    gate_overlap_a:
        assert property (status.high_gate |-> !status.low_gate
            && !$past(status.low_gate)) else $error("gate overlap");
    cover property ($rose(status.hiccup));
    cover property ($fell(status.ramp_busy));
    cover property (status.ext_ss_discharge);
endmodule : bhs_seq_chk
bind bhs_sequencer bhs_seq_chk #(.COOL_CYCLES(COOL_CYCLES),
    .SS_CYCLES(SS_CYCLES)) i_chk (.sys_clk, .sys_rst, .highside_overlimit,
    .output_undervoltage_detect, .supply_undervoltage_lockout, .shutdown,
    .bandgap_ref, .ext_soft_start_level, .status);
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking bench for the hiccup sequencer with a power-stage model.
// Assumes shortened cool-down (200) and ramp (2048) counts.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import bhs_pkg::*;
    localparam int COOL = 200;
    logic sys_clk = 0;
    logic sys_rst = 1;
    logic lo_f = 0, hs_f = 0, uv_f = 0, lock = 0, sd = 0;
    logic lso, hso, uvd, pwm;
    logic [REF_W-1:0] bg = '0, ext = '0;
    bhs_out_s st;
    int n_fail = 0, samples_checked = 0, cyc = 0, n;
    always #25 sys_clk = ~sys_clk;
    bhs_sequencer #(.COOL_CYCLES(COOL), .SS_CYCLES(2048)) i_dut (
        .sys_clk, .sys_rst, .lowside_overlimit(lso),
        .highside_overlimit(hso), .output_undervoltage_detect(uvd),
        .pwm_on(pwm), .supply_undervoltage_lockout(lock), .shutdown(sd),
        .bandgap_ref(bg), .ext_soft_start_level(ext), .status(st));
    bhs_stage i_stage (.sys_clk, .high_gate(st.high_gate),
        .low_gate(st.low_gate), .lo_f, .hs_f, .uv_f,
        .lowside_overlimit(lso), .highside_overlimit(hso),
        .output_undervoltage_detect(uvd), .pwm_on(pwm));
    task automatic tick(input int c = 1);
        repeat (c) @(posedge sys_clk);
        #2;
    endtask : tick
    function automatic logic pick(input int s);
        return s == 0 ? st.hiccup : s == 1 ? st.ramp_busy : st.uv_enabled;
    endfunction : pick
    function automatic logic [9:0] exp_ref(input logic [9:0] a, b);
        return a < b ? a : b;
    endfunction : exp_ref
    task automatic wt(input int s, input logic v, input int lim,
        output int k);
        k = 0;
        while (pick(s) !== v && k < lim)
        begin
            tick();
            k++;
        end
    endtask : wt
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("mismatch %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    task automatic trip(input string nm, input int lo, input int hi);
        int m;
        wt(0, 1'b1, 1100, m);
        chk("trip delay", 1, m >= lo && m <= hi);
        chk("gates", 0, {st.high_gate, st.low_gate});
        chk("zero ref", 0, st.reference);
        chk("kept ss", 0, st.ext_ss_discharge);
        {lo_f, hs_f, uv_f} = '0;
        wt(0, 1'b0, 300, m);
        chk("cool", COOL, m);
        chk("ramp", 1, st.ramp_busy);
        $display("test %s done", nm);
    endtask : trip
    task automatic run_wait();
        bg = 10'($urandom);
        ext = 10'($urandom);
        tick(2);
        wt(2, 1'b1, 2200, n);
        chk("run", 1, st.uv_enabled);
        chk("ref", exp_ref(bg, ext), st.reference);
    endtask : run_wait
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_fail++;
            complete_run();
        end
    end
    initial
    begin
        void'($urandom(32'hD210));
        tick(2);
        sys_rst = 0;
        uv_f = 1;
        run_wait();
        chk("uv in ramp", 0, st.hiccup);
        trip("undervoltage", 136, 150);
        hs_f = 1;
        trip("high side", 5, 90);
        run_wait();
        lo_f = 1;
        wt(0, 1'b1, 858, n);
        lo_f = 0;
        wt(0, 1'b1, 2640, n);
        lo_f = 1;
        wt(0, 1'b1, 858, n);
        lo_f = 0;
        chk("counter clear", 858, n);
        $display("test clear done");
        tick(2640);
        lo_f = 1;
        trip("low side", 924, 1000);
        run_wait();
        for (int j = 0; j < 2; j++)
        begin
            {lock, sd} = j ? 2'b01 : 2'b10;
            tick(8);
            chk("discharge", 1, st.ext_ss_discharge);
            {lock, sd} = '0;
            tick(8);
            chk("discharge off", 0, st.ext_ss_discharge);
            run_wait();
            $display("test lockout done");
        end
        complete_run();
    end
endmodule : tb
`default_nettype wire
